// ---- common/wake_pkg.sv ----
package wake_pkg;

    // Register byte offsets on the APB window
    localparam logic [7:0] OFS_PM_CTRL  = 8'h00;
    localparam logic [7:0] OFS_WAKE_POL = 8'h04;
    localparam logic [7:0] OFS_GATE_CFG = 8'h08;
    localparam logic [7:0] OFS_PIN_CFG  = 8'h0C;
    localparam logic [7:0] OFS_INTERRUPT_STATUS_REG  = 8'h10;
    localparam logic [7:0] OFS_MAC_WAKE = 8'h14;

    // Line counts
    localparam int GPIO_LINES = 11;
    localparam int GATED_LINES = 8;
    localparam int SHARED_LINES = 3;
    localparam int LINK_LINE = 7;

    // Power management control fields
    localparam int PM_SEL_LSB = 0;
    localparam int PM_NET_EN = 2;
    localparam int PM_ENERGY_DETECT_WAKE_ENABLE = 3;
    localparam int PM_WSTAT_LSB = 4;
    localparam int PM_EDPD_CTL = 6;
    localparam int PM_SUSPENDED = 8;
    localparam int PM_WAKING = 9;

    // Wake enable and polarity fields
    localparam int WP_POL_LSB = 16;
    localparam int WP_LINK_EN = 31;

    // Shared pin config fields: function 2 bits per line, then direction
    localparam int PC_DIR_LSB = 8;
    localparam logic [1:0] FUNC_GPIO = 2'h0;

    // MAC wakeup control and status fields
    localparam int MW_SA_EN = 0;
    localparam int MW_BC_EN = 1;
    localparam int MW_FRX_LSB = 4;

    // Wake status bit positions
    localparam int WS_ENERGY = 0;
    localparam int WS_NET = 1;

    // Reset values
    localparam logic EDPD_CTL_RST = 1'b1;

    typedef enum logic [1:0] {
        ST_NORMAL    = 2'b00,
        ST_SUSPENDED = 2'b01,
        ST_WAKING    = 2'b10
    } pm_state_t;

    typedef enum logic [1:0] {
        SUSP_0 = 2'b00,
        SUSP_1 = 2'b01,
        SUSP_2 = 2'b10,
        SUSP_3 = 2'b11
    } susp_sel_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [10:0] gpio_pin;
        logic        phy_link_up;
        logic        phy_energy_int;
        logic        rx_station_hit;
        logic        rx_broadcast_hit;
        logic        rx_good_frame;
    } wake_src_t;

endpackage

// ---- core/remote_wake_enable_logic.sv ----
// Summary of operation
// - Link-up wake uses line 7, only in suspend states 0 or 3.
// - Line 7 pin level ignored while it carries link-up wake.
// - GPIO wake stays suspended, raises wake, sets line status.
// - Stale network status wakes at once when network enable set.
// - Network status bit stays set while MAC event is asserted.
// - Selector stays readable; frame-received bits show wake cause.
// - In energy power-down, no frames pass; PHY flags line activity.
// - Energy status bit stays set while PHY interrupt asserted.
// - Energy detected while armed stays suspended, raises wake.
// - Stale line 7 status causes an immediate wake.
// - Good frame in suspend state 3 stays suspended, wakes.
// - Network wake only in state 0, energy wake only in state 1.
// - Lines 8-10 wake gating derived from function and direction.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module remote_wake_enable_logic (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire wake_pkg::apb_req_t  apb_req,
    output wire wake_pkg::apb_rsp_t  apb_rsp,
    input  wire wake_pkg::wake_src_t wake_src,
    input  wire logic                usb_suspend,
    output wire logic                remote_wake,
    output wire logic                suspended,
    output wire logic                phy_edpd_on
);

    typedef struct packed {
        wake_pkg::pm_state_t state;
        wake_pkg::susp_sel_t sel;
        logic                net_en;
        logic                energy_detect_wake_enable;
        logic                edpd_ctl;
        logic [1:0]          wstat;
        logic [10:0]         gwake_en;
        logic [10:0]         gpol;
        logic                link_en;
        logic [7:0]          gate;
        logic [5:0]          func;
        logic [2:0]          dir;
        logic [10:0]         gint;
        logic                sa_en;
        logic                bc_en;
        logic [2:0]          frx;
        logic [10:0]         src_prev;
        logic                remote_wake;
        logic                suspended;
        logic                edpd_on;
        wake_pkg::apb_rsp_t  rsp;
    } core_t;

    core_t st_ff;
    core_t nxt_st;

    logic [10:0] src_lvl;
    logic [10:0] gate_ok;
    logic [10:0] gpio_hit;
    logic        link_state_ok;
    logic        good_mode;
    logic        mac_evt;
    logic        good_evt;
    logic        net_hit;
    logic        ed_hit;
    logic        wake_req;
    logic        access;
    logic        fire;
    logic [31:0] rd_data;
    logic        rd_err;

    // Line counts must tile the pin fields; the link line must be gated
    if (($bits(wake_src.gpio_pin) != wake_pkg::GPIO_LINES) ||
        (wake_pkg::GATED_LINES + wake_pkg::SHARED_LINES !=
         wake_pkg::GPIO_LINES) ||
        (wake_pkg::LINK_LINE >= wake_pkg::GATED_LINES)) begin : g_bad_cfg
        $error("line counts do not fit the wake logic");
    end

    // Link-up wake counts only in suspend states 0 and 3
    // link-up state gate
    assign link_state_ok = (st_ff.sel == wake_pkg::SUSP_0) ||
                           (st_ff.sel == wake_pkg::SUSP_3);

    // Per-line active level, gating and wake hit
    for (genvar i = 0; i < wake_pkg::GPIO_LINES; i++) begin : g_line
        if (i == wake_pkg::LINK_LINE) begin : g_link
            assign src_lvl[i] = st_ff.link_en ? wake_src.phy_link_up :
                (wake_src.gpio_pin[i] == st_ff.gpol[i]);
            // link mode needs state 0 or 3
            assign gpio_hit[i] = st_ff.gint[i] & st_ff.gwake_en[i] &
                gate_ok[i] & (~st_ff.link_en | link_state_ok);
        end else begin : g_plain
            assign src_lvl[i] = (wake_src.gpio_pin[i] == st_ff.gpol[i]);
            assign gpio_hit[i] = st_ff.gint[i] & st_ff.gwake_en[i] &
                gate_ok[i];
        end
        if (i < wake_pkg::GATED_LINES) begin : g_gated
            assign gate_ok[i] = ~st_ff.gate[i];
        end else begin : g_shared
            assign gate_ok[i] =
                (st_ff.func[2*(i-wake_pkg::GATED_LINES) +: 2] ==
                 wake_pkg::FUNC_GPIO) &&
                !st_ff.dir[i-wake_pkg::GATED_LINES];
        end
    end

    // Frame events; none pass while the PHY sits in energy power-down
    // no frames in power-down
    assign good_mode = ~st_ff.sa_en & ~st_ff.bc_en;
    assign mac_evt = ~st_ff.edpd_on &
        ((wake_src.rx_station_hit & st_ff.sa_en) |
         (wake_src.rx_broadcast_hit & st_ff.bc_en));
    assign good_evt = ~st_ff.edpd_on & good_mode & wake_src.rx_good_frame;

    // Status combined with enable and selected state
    // state-qualified network and energy
    // good frame only in state 3
    assign net_hit = st_ff.wstat[wake_pkg::WS_NET] &
        ((st_ff.net_en & (st_ff.sel == wake_pkg::SUSP_0)) |
         (good_mode & (st_ff.sel == wake_pkg::SUSP_3)));
    assign ed_hit = st_ff.wstat[wake_pkg::WS_ENERGY] & st_ff.energy_detect_wake_enable &
        (st_ff.sel == wake_pkg::SUSP_1);
    // stale line status wakes at once
    assign wake_req = (|gpio_hit) | net_hit | ed_hit;

    // APB: one wait state, write lands on the pready edge
    assign access = apb_req.psel & apb_req.penable;
    assign fire = access & st_ff.rsp.pready;

    // Read mux; unmapped addresses answer with an error
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (apb_req.paddr == wake_pkg::OFS_PM_CTRL) begin
            rd_data[wake_pkg::PM_SEL_LSB +: 2] = st_ff.sel;
            rd_data[wake_pkg::PM_NET_EN] = st_ff.net_en;
            rd_data[wake_pkg::PM_ENERGY_DETECT_WAKE_ENABLE] = st_ff.energy_detect_wake_enable;
            rd_data[wake_pkg::PM_WSTAT_LSB +: 2] = st_ff.wstat;
            rd_data[wake_pkg::PM_EDPD_CTL] = st_ff.edpd_ctl;
            rd_data[wake_pkg::PM_SUSPENDED] = st_ff.suspended;
            rd_data[wake_pkg::PM_WAKING] = st_ff.remote_wake;
        end else if (apb_req.paddr == wake_pkg::OFS_WAKE_POL) begin
            rd_data[10:0] = st_ff.gwake_en;
            rd_data[wake_pkg::WP_POL_LSB +: 11] = st_ff.gpol;
            rd_data[wake_pkg::WP_LINK_EN] = st_ff.link_en;
        end else if (apb_req.paddr == wake_pkg::OFS_GATE_CFG) begin
            rd_data[7:0] = st_ff.gate;
        end else if (apb_req.paddr == wake_pkg::OFS_PIN_CFG) begin
            rd_data[5:0] = st_ff.func;
            rd_data[wake_pkg::PC_DIR_LSB +: 3] = st_ff.dir;
        end else if (apb_req.paddr == wake_pkg::OFS_INTERRUPT_STATUS_REG) begin
            rd_data[10:0] = st_ff.gint;
        end else if (apb_req.paddr == wake_pkg::OFS_MAC_WAKE) begin
            rd_data[wake_pkg::MW_SA_EN] = st_ff.sa_en;
            rd_data[wake_pkg::MW_BC_EN] = st_ff.bc_en;
            rd_data[wake_pkg::MW_FRX_LSB +: 3] = st_ff.frx;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Next state: bus writes first, then hardware sets win over clears
    always_comb begin
        nxt_st = st_ff;
        nxt_st.src_prev = src_lvl;
        nxt_st.rsp.pready = access & ~st_ff.rsp.pready;
        if (access && !st_ff.rsp.pready) begin
            nxt_st.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_data;
            nxt_st.rsp.pslverr = rd_err;
        end
        if (fire && apb_req.pwrite) begin
            if (apb_req.paddr == wake_pkg::OFS_PM_CTRL) begin
                nxt_st.sel = wake_pkg::susp_sel_t'(
                    apb_req.pwdata[wake_pkg::PM_SEL_LSB +: 2]);
                nxt_st.net_en = apb_req.pwdata[wake_pkg::PM_NET_EN];
                nxt_st.energy_detect_wake_enable = apb_req.pwdata[wake_pkg::PM_ENERGY_DETECT_WAKE_ENABLE];
                nxt_st.edpd_ctl = apb_req.pwdata[wake_pkg::PM_EDPD_CTL];
                nxt_st.wstat = st_ff.wstat &
                    ~apb_req.pwdata[wake_pkg::PM_WSTAT_LSB +: 2];
            end else if (apb_req.paddr == wake_pkg::OFS_WAKE_POL) begin
                nxt_st.gwake_en = apb_req.pwdata[10:0];
                nxt_st.gpol = apb_req.pwdata[wake_pkg::WP_POL_LSB +: 11];
                nxt_st.link_en = apb_req.pwdata[wake_pkg::WP_LINK_EN];
            end else if (apb_req.paddr == wake_pkg::OFS_GATE_CFG) begin
                nxt_st.gate = apb_req.pwdata[7:0];
            end else if (apb_req.paddr == wake_pkg::OFS_PIN_CFG) begin
                nxt_st.func = apb_req.pwdata[5:0];
                nxt_st.dir = apb_req.pwdata[wake_pkg::PC_DIR_LSB +: 3];
            end else if (apb_req.paddr == wake_pkg::OFS_INTERRUPT_STATUS_REG) begin
                nxt_st.gint = st_ff.gint & ~apb_req.pwdata[10:0];
            end else if (apb_req.paddr == wake_pkg::OFS_MAC_WAKE) begin
                nxt_st.sa_en = apb_req.pwdata[wake_pkg::MW_SA_EN];
                nxt_st.bc_en = apb_req.pwdata[wake_pkg::MW_BC_EN];
                nxt_st.frx = st_ff.frx &
                    ~apb_req.pwdata[wake_pkg::MW_FRX_LSB +: 3];
            end
        end
        // line status set on a gated active edge
        nxt_st.gint = nxt_st.gint | (src_lvl & ~st_ff.src_prev & gate_ok);
        // set held while the MAC event stands
        nxt_st.wstat[wake_pkg::WS_NET] = nxt_st.wstat[wake_pkg::WS_NET] |
            mac_evt | good_evt;
        // set held while the PHY interrupt stands
        nxt_st.wstat[wake_pkg::WS_ENERGY] =
            nxt_st.wstat[wake_pkg::WS_ENERGY] | wake_src.phy_energy_int;
        // frame type that caused the wake
        nxt_st.frx = nxt_st.frx | {good_evt,
            wake_src.rx_broadcast_hit & st_ff.bc_en & ~st_ff.edpd_on,
            wake_src.rx_station_hit & st_ff.sa_en & ~st_ff.edpd_on};
        // Power-down active while its control bit is clear
        nxt_st.edpd_on = ~nxt_st.edpd_ctl;
        // Suspend and wake sequencing
        case (st_ff.state)
            wake_pkg::ST_NORMAL: begin
                if (usb_suspend) begin
                    nxt_st.state = wake_pkg::ST_SUSPENDED;
                end
            end
            wake_pkg::ST_SUSPENDED: begin
                if (!usb_suspend) begin
                    nxt_st.state = wake_pkg::ST_NORMAL;
                end else if (wake_req) begin
                    nxt_st.state = wake_pkg::ST_WAKING;
                end
            end
            wake_pkg::ST_WAKING: begin
                if (!usb_suspend) begin
                    nxt_st.state = wake_pkg::ST_NORMAL;
                end
            end
            default: begin
                nxt_st.state = wake_pkg::ST_NORMAL;
            end
        endcase
        nxt_st.remote_wake = (nxt_st.state == wake_pkg::ST_WAKING);
        nxt_st.suspended = (nxt_st.state != wake_pkg::ST_NORMAL);
    end

    // Single register stage for all state
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.edpd_ctl <= wake_pkg::EDPD_CTL_RST;
            // Levels already active at release are not taken as edges
            st_ff.src_prev <= {wake_pkg::GPIO_LINES{1'b1}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign apb_rsp = st_ff.rsp;
    assign remote_wake = st_ff.remote_wake;
    assign suspended = st_ff.suspended;
    assign phy_edpd_on = st_ff.edpd_on;

    // Checks on the wake path
    a_pin_ignored: assert property (
        @(posedge clk) disable iff (rst)
        $rose(st_ff.gint[wake_pkg::LINK_LINE]) && $past(st_ff.link_en)
        && !$past(fire) |-> $past(wake_src.phy_link_up))
        else $error("line 7 status rose without link-up in link mode");

    a_link_state: assert property (
        @(posedge clk) disable iff (rst)
        st_ff.state == wake_pkg::ST_SUSPENDED && usb_suspend &&
        st_ff.link_en && !link_state_ok && !net_hit && !ed_hit &&
        (gpio_hit & 11'h77F) == 11'h000 |=> !remote_wake)
        else $error("link-up wake outside states 0 and 3");

    a_gpio_wake: assert property (
        @(posedge clk) disable iff (rst)
        st_ff.state == wake_pkg::ST_SUSPENDED && usb_suspend &&
        (|gpio_hit) |=> remote_wake && suspended)
        else $error("enabled line status did not raise wake");

    a_net_hold: assert property (
        @(posedge clk) disable iff (rst)
        mac_evt |=> st_ff.wstat[wake_pkg::WS_NET] [*1])
        else $error("network status dropped under MAC event");

    a_energy_hold: assert property (
        @(posedge clk) disable iff (rst)
        wake_src.phy_energy_int ##1 wake_src.phy_energy_int |->
        st_ff.wstat[wake_pkg::WS_ENERGY] ##1
        st_ff.wstat[wake_pkg::WS_ENERGY])
        else $error("energy status dropped under PHY interrupt");

    a_energy_wake: assert property (
        @(posedge clk) disable iff (rst)
        st_ff.state == wake_pkg::ST_SUSPENDED && usb_suspend &&
        st_ff.energy_detect_wake_enable && st_ff.wstat[wake_pkg::WS_ENERGY] &&
        st_ff.sel == wake_pkg::SUSP_1 |=> remote_wake)
        else $error("armed energy detect did not wake");

    a_net_state: assert property (
        @(posedge clk) disable iff (rst)
        $rose(remote_wake) && $past(gpio_hit) == 11'h000 &&
        !$past(ed_hit) && $past(st_ff.net_en) && !$past(good_mode) |->
        $past(st_ff.sel) == wake_pkg::SUSP_0)
        else $error("network wake outside state 0");

    a_wake_held: assert property (
        @(posedge clk) disable iff (rst)
        remote_wake && usb_suspend |=> remote_wake)
        else $error("remote wake dropped before resume");

    a_sel_kept: assert property (
        @(posedge clk) disable iff (rst)
        !(fire && apb_req.pwrite) |=> $stable(st_ff.sel))
        else $error("selector changed without a write");

    a_shared_gate: assert property (
        @(posedge clk) disable iff (rst)
        $rose(st_ff.gint[8]) |->
        $past(st_ff.func[1:0]) == wake_pkg::FUNC_GPIO && !$past(st_ff.dir[0]))
        else $error("line 8 status set while not a GPIO input");

    a_edpd_block: assert property (
        @(posedge clk) disable iff (rst)
        st_ff.edpd_on && !st_ff.wstat[wake_pkg::WS_NET] |=>
        !st_ff.wstat[wake_pkg::WS_NET])
        else $error("frame status set during energy power-down");

    a_stale_net: assert property (
        @(posedge clk) disable iff (rst)
        st_ff.state == wake_pkg::ST_SUSPENDED && usb_suspend &&
        st_ff.wstat[wake_pkg::WS_NET] && st_ff.net_en &&
        st_ff.sel == wake_pkg::SUSP_0 |=> remote_wake)
        else $error("pending network status did not wake");

endmodule

// ---- testbench/wake_host_model.sv ----
`timescale 1ns/1ps
// Host driver: APB accesses and bus suspend signalling
module wake_host_model (
    input  wire logic               clk,
    output wake_pkg::apb_req_t      apb_req,
    input  wire wake_pkg::apb_rsp_t apb_rsp,
    output logic                    usb_suspend
);
    logic hung = 1'b0;

    // Idle bus and no suspend from time zero
    initial begin
        apb_req = '0;
        usb_suspend = 1'b0;
    end

    // Request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        int n;
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb_req <= '{1'b1, 1'b1, w, a, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 40);
        if (apb_rsp.pready !== 1'b1) hung = 1'b1;
        q = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '{1'b0, 1'b0, w, a, d};
    endtask

    task automatic go_suspend(input logic [31:0] pm);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, wake_pkg::OFS_PM_CTRL, pm, q, e);
        @(posedge clk);
        usb_suspend <= 1'b1;
    endtask

    // Host resume ends the suspend
    task automatic resume();
        @(posedge clk);
        usb_suspend <= 1'b0;
    endtask
endmodule

// ---- testbench/remote_wake_enable_logic_tb.sv ----
`timescale 1ns/1ps
module remote_wake_enable_logic_tb;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    wake_pkg::wake_src_t src = '0;
    wake_pkg::apb_req_t  apb_req;
    wake_pkg::apb_rsp_t  apb_rsp;
    logic                usb_suspend;
    logic                remote_wake;
    logic                suspended;
    logic                phy_edpd_on;
    logic [31:0]         q;
    logic                e;
    int                  n_errors = 0;
    int                  cmp_count = 0;

    // Core clock, 5 ns period
    always #2.5 clk = ~clk;

    remote_wake_enable_logic uut (
        .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .wake_src(src), .usb_suspend(usb_suspend),
        .remote_wake(remote_wake), .suspended(suspended),
        .phy_edpd_on(phy_edpd_on)
    );

    wake_host_model host (
        .clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .usb_suspend(usb_suspend)
    );

    task automatic close_out();
        if (host.hung) n_errors++;
        $display("counts errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q, e);
        if (host.hung) close_out();
    endtask

    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, q, e);
        if (host.hung) close_out();
    endtask

    // Short reset; pins rest at their inactive level
    task automatic do_reset(input logic [10:0] idle);
        @(posedge clk);
        rst <= 1'b1;
        src <= {idle, 5'h0};
        @(posedge clk);
        rst <= 1'b0;
    endtask

    // pin 7 driven active too, it must not count
    task automatic fire(input int k, input int l, input logic [10:0] pol);
        wake_pkg::wake_src_t v;
        v = src;
        case (k)
            0, 1: v.gpio_pin[l] = pol[l];
            2: v.rx_station_hit = 1'b1;
            3: v.rx_broadcast_hit = 1'b1;
            4: v.rx_good_frame = 1'b1;
            5: {v.phy_energy_int, v.rx_station_hit} = 2'b11;
            default: {v.phy_link_up, v.gpio_pin[7]} = 2'b11;
        endcase
        src <= v;
    endtask

    // which source wakes in which state
    function automatic logic exp_wake(input int k, input int s);
        case (k)
            0: return 1'b1;
            1: return 1'b0;
            2, 3: return s == 0;
            4: return s == 3;
            5: return s == 1;
            default: return s == 0 || s == 3;
        endcase
    endfunction

    // Kinds: gpio, gated gpio, station, broadcast, good, energy, link
    initial begin
        int          k, s, st, l, w;
        logic [10:0] pol;
        logic [31:0] pm, m;
        logic [7:0]  oa;
        logic        x;
        void'($urandom(32));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4));
            chk_word(q, (i == 0) ? 32'h40 : 32'h0);
            chk_bit(e, i == 6);
        end
        for (int t = 0; t < 56; t++) begin
            st = t / 28;
            k = (t / 4) % 7;
            s = t % 4;
            l = (k == 6) ? 7 : $urandom_range(10);
            pol = 11'($urandom);
            if (k == 6) pol[7] = 1'b1;
            do_reset(~pol);
            wr(wake_pkg::OFS_WAKE_POL, (k < 2) ?
               ((32'h1 << l) | {5'h0, pol, 16'h0}) :
               ((k == 6) ? 32'h8080_0080 : 32'h0));
            wr(wake_pkg::OFS_GATE_CFG,
               (k == 1) ? 32'hFF : (32'hFF & ~(32'h1 << l)));
            wr(wake_pkg::OFS_PIN_CFG, (k != 1) ? 32'h0 :
               ($urandom_range(1) ? 32'h700 : 32'h3F));
            // frame enables, none for good frames
            wr(wake_pkg::OFS_MAC_WAKE, (k == 2 || k == 5) ? 32'h1 :
               ((k == 3) ? 32'h2 : 32'h0));
            pm = (k == 5) ? 32'h0 : 32'h40;
            wr(wake_pkg::OFS_PM_CTRL, pm | 32'h30);
            wr(wake_pkg::OFS_INTERRUPT_STATUS_REG, 32'h7FF);
            pm = pm | ((k inside {2, 3, 5}) ? 32'h4 : 32'h0);
            pm = pm | ((k == 5) ? 32'h8 : 32'h0);
            wr(wake_pkg::OFS_PM_CTRL, pm);
            chk_bit(phy_edpd_on, k == 5);
            // Stale pass: the event lands before suspend
            if (st == 1) begin
                fire(k, l, pol);
                repeat (3) @(posedge clk);
                if (k inside {2, 3, 5}) begin
                    wr(wake_pkg::OFS_PM_CTRL, pm | 32'h30);
                    rd(wake_pkg::OFS_PM_CTRL);
                    chk_bit(q[(k == 5) ? 4 : 5], 1'b1);
                end
            end
            host.go_suspend(pm | 32'(s));
            if (st == 0) begin
                repeat (3) @(posedge clk);
                fire(k, l, pol);
            end
            w = 0;
            while (remote_wake !== 1'b1 && w < 12) begin
                @(posedge clk);
                w++;
            end
            x = exp_wake(k, s);
            chk_bit(remote_wake, x);
            if (remote_wake !== x) close_out();
            rd(wake_pkg::OFS_PM_CTRL);
            chk_word(q & 32'h303, {22'h0, x, 1'b1, 6'h0, 2'(s)});
            m = (k == 0 || k == 6) ? (32'h1 << l) :
                ((k == 5) ? 32'h10 : (32'h10 << (k - 2)));
            oa = (k == 0 || k == 6) ? wake_pkg::OFS_INTERRUPT_STATUS_REG :
                 ((k == 5) ? wake_pkg::OFS_PM_CTRL : wake_pkg::OFS_MAC_WAKE);
            if (x) begin
                rd(oa);
                chk_word(q & m, m);
            end
            chk_bit(remote_wake, x);
            chk_bit(suspended, 1'b1);
            host.resume();
            repeat (3) @(posedge clk);
            chk_bit(remote_wake | suspended, 1'b0);
            $display("test kind=%0d sel=%0d stale=%0d done", k, s, st);
        end
        close_out();
    end
endmodule
